// ---- tb/qa_watchdog_answer_checker_tb.sv ----
// Bench for the Q&A watchdog checker over its Avalon-MM port.
// Assumes short windows of 20 cycles and the package register map.
`timescale 1ns/1ps
module qa_watchdog_answer_checker_tb;
  import qawd_pkg::*;
  localparam int unsigned WIN = 20;
  logic clk = 0;
  logic rst = 1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdat;
  logic avs_waitrequest, irq, wd_reset_pulse;
  logic bad = 0;
  logic [1:0] sel = 2'b11;
  logic [7:0] ans;
  qawd_view_t wd_view;
  int err_total = 0;
  int n_compared = 0;
  always #4 clk = ~clk;
  qawd_checker #(.WIN_CYC(WIN)) uut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .wd_reset_pulse(wd_reset_pulse), .wd_view(wd_view));
  qawd_mcu mcu (.question(wd_view.question), .sel(sel), .corrupt(bad), .answer(ans));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic put(input logic [1:0] i, input logic b);
    sel = i;
    bad = b;
    // Let the model settle on the new index before its byte is taken
    #1;
    acc(1'b1, QAWD_OFS_ANS, {24'h0, ans});
  endtask
  task automatic three_one(input logic b);
    put(2'b11, b);
    put(2'b10, 1'b0);
    put(2'b01, 1'b0);
    repeat (WIN) @(posedge clk);
    put(2'b00, 1'b0);
  endtask
  task automatic view(input logic [3:0] q, input logic a, input logic w, input logic [3:0] f);
    @(negedge clk);
    chk("view", 32'(wd_view), {20'h0, q, 2'b11, a, w, f});
  endtask
  task automatic wait_fail;
    logic [3:0] f;
    f = wd_view.fails;
    while (wd_view.fails === f) @(negedge clk);
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    view(4'h0, 0, 0, 4'h0);
    acc(1'b0, QAWD_OFS_CFG, 32'h0);
    chk("cfg", rdat, QAWD_CFG_RST);
    acc(1'b0, 5'h14, 32'h0);
    chk("unmapped", rdat, 32'h0);
    $display("test registers done");
    acc(1'b1, QAWD_OFS_CFG, 32'h301);
    three_one(1'b0);
    view(4'h1, 0, 0, 4'h0);
    acc(1'b0, QAWD_OFS_QST, 32'h0);
    chk("question", rdat, 32'h0000_0031);
    wait_fail;
    view(4'h1, 0, 1, 4'h1);
    repeat (22) @(posedge clk);
    put(3, 0);
    put(2, 0);
    put(1, 0);
    put(0, 0);
    view(4'h1, 0, 1, 4'h2);
    acc(1'b1, QAWD_OFS_MSK, 32'h4);
    put(3, 1);
    put(2, 0);
    repeat (WIN) @(posedge clk);
    put(1, 0);
    wait_fail;
    view(4'h1, 1, 1, 4'h3);
    chk("irq", irq, 1);
    acc(1'b1, QAWD_OFS_STS, 32'h4);
    @(negedge clk);
    chk("irq", irq, 0);
    $display("test failed sequences done");
    acc(1'b1, QAWD_OFS_CFG, 32'h303);
    repeat (60) @(posedge clk);
    view(4'h1, 1, 1, 4'h3);
    acc(1'b1, QAWD_OFS_CFG, 32'h345);
    three_one(1'b0);
    view(4'h1, 1, 1, 4'h4);
    chk("pulse", wd_reset_pulse, 1);
    @(negedge clk);
    chk("pulse", wd_reset_pulse, 0);
    acc(1'b1, QAWD_OFS_CFG, 32'h300);
    acc(1'b1, QAWD_OFS_CFG, 32'h311);
    three_one(1'b0);
    view(4'h1, 1, 1, 4'h5);
    chk("pulse", wd_reset_pulse, 0);
    acc(1'b1, QAWD_OFS_CFG, 32'h300);
    acc(1'b1, QAWD_OFS_CFG, 32'h301);
    three_one(1'b0);
    view(4'h2, 0, 0, 4'h4);
    $display("test mode settings done");
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    print_verdict;
  end
endmodule // qa_watchdog_answer_checker_tb

// ---- tb/qawd_assertions.sv ----
// Port-level checks of the Q&A watchdog checker.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module qawd_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Events and view
  input wire logic wd_reset_pulse,
  input wire qawd_pkg::qawd_view_t wd_view
);
  import qawd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence q_step;
    !$past(rst) && (wd_view.question != $past(wd_view.question));
  endsequence
  sequence fail_step;
    !$past(rst) && (wd_view.fails == $past(wd_view.fails) + 4'h1);
  endsequence
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  no_req_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait without request");
  q_nonzero_a: assert property (q_step |-> wd_view.question != 4'h0)
    else $error("question became zero");
  good_flags_a: assert property (q_step |-> !wd_view.werr && !wd_view.aerr && wd_view.idx == 2'b11)
    else $error("flags or index wrong after good sequence");
  good_dec_a: assert property (q_step |-> wd_view.fails == (($past(wd_view.fails) == 4'h0) ?
    4'h0 : $past(wd_view.fails) - 4'h1))
    else $error("fail count not lowered");
  fail_keep_a: assert property (fail_step |-> $stable(wd_view.question) && wd_view.werr)
    else $error("failed sequence changed question");
  aerr_werr_a: assert property (wd_view.aerr |-> wd_view.werr)
    else $error("answer error without watchdog error");
  pulse_one_a: assert property ($rose(wd_reset_pulse) |-> wd_view.fails != 4'h0 ##1 !wd_reset_pulse)
    else $error("bad failure pulse");
endmodule // qawd_assertions
bind qawd_checker qawd_assertions u_qawd_sva (.clk(clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .wd_reset_pulse(wd_reset_pulse),
  .wd_view(wd_view));

// ---- tb/qawd_mcu.sv ----
// Microcontroller model: computes one answer byte for a question.
// Assumes the bench picks the byte index and any corruption.
`timescale 1ns/1ps
module qawd_mcu (
  // Question and choice
  input wire logic [3:0] question,
  input wire logic [1:0] sel,
  input wire logic corrupt,
  // Answer byte
  output logic [7:0] answer
);
  localparam logic [31:0] TBL [16] = '{
    32'hff0ff000, 32'hb040bf4f, 32'he919e616, 32'ha656a959, 32'h75857a8a, 32'h3aca35c5,
    32'h63936c9c, 32'h2cdc23d3, 32'hd222dd2d, 32'h9d6d9262, 32'hc434cb3b, 32'h8b7b8474,
    32'h58a857a7, 32'h17e718e8, 32'h4ebe41b1, 32'h01f10efe};
  // Byte 3 sits highest, so index 3 is sent first
  assign answer = TBL[question][sel*8 +: 8] ^ {7'h0, corrupt};
endmodule // qawd_mcu

// ---- verilog/qawd_checker.sv ----
// Q&A watchdog checker, multi-answer mode, with Avalon-MM register slave.
// Assumes a master that holds each request until waitrequest is low.
`timescale 1ns/1ps
module qawd_checker #(
  parameter int unsigned WIN_CYC = qawd_pkg::QAWD_WIN_CYC,
  parameter logic [3:0] TAPS = qawd_pkg::QAWD_TAPS_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Events and view
  output logic irq,
  output logic wd_reset_pulse,
  output qawd_pkg::qawd_view_t wd_view
);
  import qawd_pkg::*;

  if (WIN_CYC < 2) begin : g_chk
    $error("WIN_CYC must be at least 2");
  end

  // ***************************
  // Bus slave
  // ***************************
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  qawd_cfg_t cfg_r, cfg_nxt;
  logic [QAWD_STS_W-1:0] sts_r, sts_nxt, msk_r, msk_nxt;
  logic wr_fire;
  logic [QAWD_STS_W-1:0] evt;
  logic sts_clr;

  // Reset image, unpacked field by field since the struct packs thr at bit 7 and the map at bit 8
  localparam qawd_cfg_t CFG_RST = '{
    thr: QAWD_CFG_RST[QAWD_CFG_THR +: 4],
    act: QAWD_CFG_RST[QAWD_CFG_ACT],
    ansg: QAWD_CFG_RST[QAWD_CFG_ANSG +: 2],
    poly: QAWD_CFG_RST[QAWD_CFG_POLY +: 2],
    mode: QAWD_CFG_RST[QAWD_CFG_MODE],
    en: QAWD_CFG_RST[QAWD_CFG_EN]
  };

  // Watchdog state
  qawd_state_t state_r, state_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [3:0] q_r, q_nxt;
  logic [1:0] idx_r, idx_nxt;
  logic [1:0] w1_r, w1_nxt;
  logic [2:0] tot_r, tot_nxt;
  logic bad_r, bad_nxt;
  logic aerr_r, aerr_nxt, werr_r, werr_nxt;
  logic [3:0] fails_r, fails_nxt;
  logic rpulse_r, rpulse_nxt;

  assign wr_fire = avs_write & ack_r;
  // One wait state on every access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata = rdata_r;
  assign irq = |(sts_r & msk_r);
  assign wd_reset_pulse = rpulse_r;
  assign wd_view = '{
    question: q_r,
    idx: idx_r,
    aerr: aerr_r,
    werr: werr_r,
    fails: fails_r
  };

  always_comb begin
    ack_nxt = (avs_read | avs_write) & ~ack_r;
    rdata_nxt = rdata_r;
    cfg_nxt = cfg_r;
    msk_nxt = msk_r;
    if (!ack_r) begin
      rdata_nxt = 32'h0000_0000;
      if (avs_address == QAWD_OFS_CFG) begin
        rdata_nxt[QAWD_CFG_THR +: 4] = cfg_r.thr;
        rdata_nxt[QAWD_CFG_ACT] = cfg_r.act;
        rdata_nxt[QAWD_CFG_ANSG +: 2] = cfg_r.ansg;
        rdata_nxt[QAWD_CFG_POLY +: 2] = cfg_r.poly;
        rdata_nxt[QAWD_CFG_MODE] = cfg_r.mode;
        rdata_nxt[QAWD_CFG_EN] = cfg_r.en;
      end else if (avs_address == QAWD_OFS_QST) begin
        rdata_nxt[QAWD_QST_Q +: 4] = q_r;
        rdata_nxt[QAWD_QST_IDX +: 2] = idx_r;
        rdata_nxt[QAWD_QST_AERR] = aerr_r;
        rdata_nxt[QAWD_QST_WERR] = werr_r;
        rdata_nxt[QAWD_QST_FAILS +: 4] = fails_r;
      end else if (avs_address == QAWD_OFS_STS) begin
        rdata_nxt[QAWD_STS_W-1:0] = sts_r;
      end else if (avs_address == QAWD_OFS_MSK) begin
        rdata_nxt[QAWD_STS_W-1:0] = msk_r;
      end
    end
    if (wr_fire) begin
      if (avs_address == QAWD_OFS_CFG) begin
        cfg_nxt.thr = avs_writedata[QAWD_CFG_THR +: 4];
        cfg_nxt.act = avs_writedata[QAWD_CFG_ACT];
        cfg_nxt.ansg = avs_writedata[QAWD_CFG_ANSG +: 2];
        cfg_nxt.poly = avs_writedata[QAWD_CFG_POLY +: 2];
        cfg_nxt.mode = avs_writedata[QAWD_CFG_MODE];
        cfg_nxt.en = avs_writedata[QAWD_CFG_EN];
      end else if (avs_address == QAWD_OFS_MSK) begin
        msk_nxt = avs_writedata[QAWD_STS_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      cfg_r <= CFG_RST;
      sts_r <= QAWD_STS_RST;
      msk_r <= QAWD_STS_RST;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      cfg_r <= cfg_nxt;
      sts_r <= sts_nxt;
      msk_r <= msk_nxt;
    end
  end

  // ***************************
  // Status bits
  // ***************************
  assign sts_clr = wr_fire && (avs_address == QAWD_OFS_STS);

  for (genvar i = 0; i < QAWD_STS_W; i++) begin : g_sts
    // Set wins over a write-one clear, so no event is lost
    assign sts_nxt[i] = evt[i] | (sts_r[i] & ~(sts_clr & avs_writedata[i]));
  end

  // ***************************
  // Answer checking
  // ***************************
  logic ans_wr, active, dflt, byte_ok, end_cyc, good, fail_hit;
  logic [31:0] tbl;
  logic [7:0] exp_byte;
  logic [3:0] fails_inc, q_gen;

  always_comb begin
    ans_wr = wr_fire && (avs_address == QAWD_OFS_ANS);
    active = cfg_r.en && !cfg_r.mode;
    dflt = (cfg_r.poly == 2'b00) && (cfg_r.ansg == 2'b00);
    tbl = QAWD_ANS[q_r];
    exp_byte = tbl[{idx_r, 3'b000} +: 8];
    byte_ok = dflt && (avs_writedata[7:0] == exp_byte);
    // Feedback over chosen taps, zero state escapes to one
    q_gen = {q_r[2:0], ^(q_r & TAPS)};
    if (q_gen == QAWD_Q_RST) begin
      q_gen = QAWD_Q_ONE;
    end
    fails_inc = (fails_r == 4'hf) ? fails_r : fails_r + 4'h1;

    state_nxt = state_r;
    tmr_nxt = tmr_r + 32'h0000_0001;
    q_nxt = q_r;
    idx_nxt = idx_r;
    w1_nxt = w1_r;
    tot_nxt = tot_r;
    bad_nxt = bad_r;
    aerr_nxt = aerr_r;
    werr_nxt = werr_r;
    fails_nxt = fails_r;
    rpulse_nxt = 1'b0;
    end_cyc = 1'b0;
    good = 1'b0;
    fail_hit = 1'b0;
    evt = '0;

    case (state_r)
      QAWD_IDLE: begin
        tmr_nxt = 32'h0000_0000;
        if (active) begin
          state_nxt = QAWD_WIN1;
          idx_nxt = QAWD_IDX_TOP;
          w1_nxt = 2'b00;
          tot_nxt = 3'b000;
          bad_nxt = 1'b0;
        end
      end
      QAWD_WIN1, QAWD_WIN2: begin
        if (ans_wr) begin
          bad_nxt = bad_r | ~byte_ok;
          idx_nxt = idx_r - 2'b01;
          tot_nxt = tot_r + 3'b001;
          if (state_r == QAWD_WIN1) begin
            w1_nxt = w1_r + 2'b01;
          end
        end
        if (tot_nxt == 3'b100) begin
          // Fourth byte closes the cycle at once
          end_cyc = 1'b1;
          good = (state_r == QAWD_WIN2) && (w1_r == 2'b11) && !bad_nxt;
        end else if (tmr_r == WIN_CYC - 1) begin
          tmr_nxt = 32'h0000_0000;
          if (state_r == QAWD_WIN1) begin
            state_nxt = QAWD_WIN2;
          end else begin
            end_cyc = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = QAWD_IDLE;
      end
    endcase

    if (end_cyc) begin
      aerr_nxt = bad_nxt;
      werr_nxt = !good;
      evt[QAWD_STS_AERR] = bad_nxt;
      evt[QAWD_STS_WERR] = !good;
      evt[QAWD_STS_GOOD] = good;
      if (good) begin
        fails_nxt = (fails_r == 4'h0) ? fails_r : fails_r - 4'h1;
        q_nxt = q_gen;
      end else begin
        fails_nxt = fails_inc;
        fail_hit = (cfg_r.thr != 4'h0) && (fails_inc >= cfg_r.thr);
      end
      evt[QAWD_STS_FAIL] = fail_hit;
      rpulse_nxt = fail_hit && cfg_r.act;
      state_nxt = QAWD_WIN1;
      tmr_nxt = 32'h0000_0000;
      idx_nxt = QAWD_IDX_TOP;
      w1_nxt = 2'b00;
      tot_nxt = 3'b000;
      bad_nxt = 1'b0;
    end
    // Leaving the mode abandons the cycle without a verdict
    if (!active) begin
      state_nxt = QAWD_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= QAWD_IDLE;
      tmr_r <= 32'h0000_0000;
      q_r <= QAWD_Q_RST;
      idx_r <= QAWD_IDX_TOP;
      w1_r <= 2'b00;
      tot_r <= 3'b000;
      bad_r <= 1'b0;
      aerr_r <= 1'b0;
      werr_r <= 1'b0;
      fails_r <= 4'h0;
      rpulse_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      q_r <= q_nxt;
      idx_r <= idx_nxt;
      w1_r <= w1_nxt;
      tot_r <= tot_nxt;
      bad_r <= bad_nxt;
      aerr_r <= aerr_nxt;
      werr_r <= werr_nxt;
      fails_r <= fails_nxt;
      rpulse_r <= rpulse_nxt;
    end
  end

endmodule // qawd_checker

// ---- verilog/qawd_pkg.sv ----
// Constants, types and answer table of the Q&A watchdog checker.
// Assumes one 125 MHz clock and a 32-bit Avalon-MM register bus.
//
// Overview of operation
// - A question state of 0000 is forced to 0001 before generation continues.
// - Answer table applies only while polynomial and answer settings are default.
// - Four answer bytes enter one register; index 3 down to 0 follows counter.
// - Each question value expects one fixed set of four bytes.
// - No answers: next cycle at window 2 end, answer error 0, watchdog error 1.
// - Four answers all in window 2: next cycle after the fourth, failed.
// - Total below four answers: failed, next cycle at the end of window 2.
// - Failed sequence raises failure counter, sets watchdog error, keeps question.
// - Answer error is 1 when any byte was wrong, else 0.
// - Evaluation runs only while the mode select bit is 0 (multi-answer).
// - Three good in window 1 plus one in window 2 lowers count, new question.
// - New question appears within one clock after the last answer byte.
// - Question generator advances only on counter rollover, a good sequence.
// - Failure count reaching threshold fires the configured failure action.
package qawd_pkg;

  // ***************************
  // Timing
  // ***************************
  localparam int unsigned QAWD_CLK_HZ = 125_000_000;
  localparam int unsigned QAWD_WIN_MS = 32;
  localparam int unsigned QAWD_WIN_CYC = QAWD_CLK_HZ / 1000 * QAWD_WIN_MS;

  // ***************************
  // Register map
  // ***************************
  localparam logic [4:0] QAWD_OFS_CFG = 5'h00;
  localparam logic [4:0] QAWD_OFS_ANS = 5'h04;
  localparam logic [4:0] QAWD_OFS_QST = 5'h08;
  localparam logic [4:0] QAWD_OFS_STS = 5'h0c;
  localparam logic [4:0] QAWD_OFS_MSK = 5'h10;

  // Config fields
  localparam int QAWD_CFG_EN = 0;
  localparam int QAWD_CFG_MODE = 1;
  localparam int QAWD_CFG_POLY = 2;
  localparam int QAWD_CFG_ANSG = 4;
  localparam int QAWD_CFG_ACT = 6;
  localparam int QAWD_CFG_THR = 8;
  localparam logic [31:0] QAWD_CFG_RST = 32'h0000_0300;

  // Status and mask bits
  localparam int QAWD_STS_AERR = 0;
  localparam int QAWD_STS_WERR = 1;
  localparam int QAWD_STS_FAIL = 2;
  localparam int QAWD_STS_GOOD = 3;
  localparam int QAWD_STS_W = 4;
  localparam logic [3:0] QAWD_STS_RST = 4'h0;

  // Question readout fields
  localparam int QAWD_QST_Q = 0;
  localparam int QAWD_QST_IDX = 4;
  localparam int QAWD_QST_AERR = 6;
  localparam int QAWD_QST_WERR = 7;
  localparam int QAWD_QST_FAILS = 8;

  localparam logic [3:0] QAWD_Q_RST = 4'h0;
  localparam logic [3:0] QAWD_Q_ONE = 4'h1;
  localparam logic [3:0] QAWD_TAPS_DEF = 4'hc;
  localparam logic [1:0] QAWD_IDX_TOP = 2'b11;

  // Bytes 3..0 packed high to low
  localparam logic [31:0] QAWD_ANS [16] = '{
    32'hff0f_f000, 32'hb040_bf4f, 32'he919_e616, 32'ha656_a959,
    32'h7585_7a8a, 32'h3aca_35c5, 32'h6393_6c9c, 32'h2cdc_23d3,
    32'hd222_dd2d, 32'h9d6d_9262, 32'hc434_cb3b, 32'h8b7b_8474,
    32'h58a8_57a7, 32'h17e7_18e8, 32'h4ebe_41b1, 32'h01f1_0efe
  };

  // ***************************
  // Types
  // ***************************
  typedef enum logic [1:0] {QAWD_IDLE, QAWD_WIN1, QAWD_WIN2} qawd_state_t;

  typedef struct packed {
    logic [3:0] thr;
    logic act;
    logic [1:0] ansg;
    logic [1:0] poly;
    logic mode;
    logic en;
  } qawd_cfg_t;

  typedef struct packed {
    logic [3:0] question;
    logic [1:0] idx;
    logic aerr;
    logic werr;
    logic [3:0] fails;
  } qawd_view_t;

endpackage
